// ==== core/gated_timer.sv ====
`timescale 1ns/1ns
`include "timer_consts.svh"
// Functional notes
// [R01] 16-bit up counter, byte writes replace bytes
// [R02] Source select: 0 instruction clock, 1 external
// [R03] External source counts rising edges
// [R04] Counter mode needs falling edge first
// [R05] Prescaler hidden, cleared by count writes
// [R06] Oscillator enable starts crystal oscillator
// [R07] Oscillator pins forced input, reads fixed
// [R08] Software waits oscillator start before enabling
// [R09] Unsynchronised mode counts during sleep
// [R10] Mode switch may lose or add increment
// [R11] Byte reads always return valid value
// [R12] Software stops timer before async writes
// [R13] Gate from pin or comparator, gated enable
// [R14] Gate inversion applies to either source
// [R15] Rollover sets sticky overflow flag
// [R16] Interrupt needs all three enables set
// [R17] Sleep overflow wakes, vectors if global
// [R18] Count is capture/compare time base
// [R19] Special event clears count, no flag
// [R20] Count write beats special event clear
// [R21] Software uses synchronous mode with trigger
// [R22] Count clock supplied to comparator sync
// [R23] Prescale codes divide by 1, 2, 4, 8
// [R24] Gate enable ignored while timer off
// [R25] Inversion 1 counts gate high, 0 low
// [R26] Counter holds its value while off
// [R27] External input synchronised, edges detected
module gated_timer
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic crystal_osc_in,
  output logic crystal_osc_out,
  input wire logic gate_pin,
  input wire logic comparator_two_output,
  input wire logic sleep,
  input wire logic capture_event,
  input wire logic special_event_trigger,
  output logic [15:0] time_base,
  output logic [15:0] capture_value,
  output logic count_clock,
  output logic synced_comparator_two_output,
  output logic osc_pin_a_oe,
  output logic osc_pin_b_oe,
  output logic overflow_irq,
  output logic wake
);

  control_t control;
  gate_ctrl_t gate_ctrl;
  irq_enable_t irq_en;
  logic overflow_flag;
  logic [1:0] osc_dir;
  logic [15:0] count;
  logic [1:0] instr_div;
  logic arm;
  logic level_at_stop;
  logic on_q;

  sync_out_t ext_sync;
  sync_out_t xtal_sync;
  sync_out_t gate_sync;
  sync_out_t comp_sync;
  sync_out_t src;

  logic setup;
  logic access;
  logic wr;
  logic wr_low;
  logic wr_high;
  logic wr_count;
  logic instr_tick;
  logic ext_mode;
  logic raw_tick;
  logic gate_level;
  logic gate_open;
  logic count_en;
  logic inc;
  logic overflow;
  logic mapped;
  logic [31:0] read_word;
  control_t next_control;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `OFS_CONTROL) || (a == `OFS_COUNT_LOW) ||
                (a == `OFS_COUNT_HIGH) || (a == `OFS_GATE_CTRL) ||
                (a == `OFS_FLAGS) || (a == `OFS_IRQ_ENABLE) ||
                (a == `OFS_OSC_PORT);
  endfunction : is_mapped

  pin_sync u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_count_input),
    .sync(ext_sync)
  );

  pin_sync u_xtal_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(crystal_osc_in),
    .sync(xtal_sync)
  );

  pin_sync u_gate_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(gate_pin),
    .sync(gate_sync)
  );

  pin_sync u_comp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(comparator_two_output),
    .sync(comp_sync)
  );

  // APB decode
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite && !pslverr;
  assign wr_low = wr && (paddr == `OFS_COUNT_LOW);
  assign wr_high = wr && (paddr == `OFS_COUNT_HIGH);
  assign wr_count = wr_low || wr_high;
  assign mapped = is_mapped(paddr);

  // With the crystal running the same pin pair carries the clock
  assign src = control.crystal_osc_enable ? xtal_sync : ext_sync; // R06
  assign ext_mode = control.clock_source_select; // R02
  assign instr_tick = (instr_div == `INSTR_DIV_LAST);

  // Sleep stops the instruction clock and the synchronised path
  // Both modes share one synchroniser: a switch risks one edge at most
  always_comb begin
    if (!ext_mode) begin
      raw_tick = instr_tick && !sleep; // R02 R17
    end else if (control.sync_disable) begin // R10
      raw_tick = src.rise && arm; // R09 R03 R04
    end else begin
      raw_tick = src.rise && arm && !sleep; // R27 R03 R04
    end
  end

  assign gate_level = gate_ctrl.gate_source_select ?
                      synced_comparator_two_output : gate_sync.level; // R13
  assign gate_open = (gate_level == control.gate_invert); // R14 R25
  assign count_en = control.timer_on &&
                    (!control.gate_enable || gate_open); // R24 R26 R13

  prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick(raw_tick && count_en),
    .clear(wr_count), // R05
    .prescale_select(control.prescale_select),
    .pulse(inc)
  );

  assign overflow = inc && (count == `COUNT_MAX) && !wr_count &&
                    !special_event_trigger; // R15 R19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // Writes first, then the special event clear, then counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= pwdata[7:0]; // R01 R20
    end else if (wr_high) begin
      count[15:8] <= pwdata[7:0]; // R01 R20
    end else if (special_event_trigger) begin
      count <= `COUNT_RESET; // R19
    end else if (inc) begin
      count <= count + 16'h0001; // R01
    end
  end

  // Falling edge needed before the first counted rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm <= 1'b0; // R04
      on_q <= 1'b0;
      level_at_stop <= 1'b0;
    end else begin
      on_q <= control.timer_on;
      if (on_q && !control.timer_on) begin
        level_at_stop <= src.level;
      end
      if (wr_count) begin
        arm <= 1'b0; // R04
      end else if (src.fall) begin
        arm <= 1'b1;
      end else if (!on_q && control.timer_on && level_at_stop &&
                   !src.level) begin
        arm <= 1'b0; // R04
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1; // R15
    end else if (wr && (paddr == `OFS_FLAGS) && !pwdata[0]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_comb begin
    next_control = control;
    if (wr && (paddr == `OFS_CONTROL)) begin
      next_control = control_t'(pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= control_t'(`CONTROL_RESET);
      gate_ctrl <= gate_ctrl_t'(`GATE_CTRL_RESET);
      irq_en <= irq_enable_t'(`IRQ_ENABLE_RESET);
      osc_dir <= `OSC_DIR_RESET;
    end else begin
      control <= next_control;
      if (wr && (paddr == `OFS_GATE_CTRL)) begin
        gate_ctrl <= gate_ctrl_t'(pwdata[1:0]);
      end
      if (wr && (paddr == `OFS_IRQ_ENABLE)) begin
        irq_en <= irq_enable_t'(pwdata[2:0]);
      end
      if (wr && (paddr == `OFS_OSC_PORT)) begin
        osc_dir <= pwdata[1:0];
      end
    end
  end

  // Count byte reads come from the held count, never mid-update
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      `OFS_CONTROL: read_word[7:0] = control;
      `OFS_COUNT_LOW: read_word[7:0] = count[7:0]; // R11
      `OFS_COUNT_HIGH: read_word[7:0] = count[15:8]; // R11
      `OFS_GATE_CTRL: read_word[1:0] = gate_ctrl;
      `OFS_FLAGS: read_word[0] = overflow_flag;
      `OFS_IRQ_ENABLE: read_word[2:0] = irq_en;
      `OFS_OSC_PORT: begin
        if (control.crystal_osc_enable) begin
          read_word[1:0] = 2'h3; // R07
        end else begin
          read_word[1:0] = osc_dir;
          read_word[2] = src.level;
        end
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  // Registered answer: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      // Writes and unmapped reads answer zero
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : read_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value <= `COUNT_RESET;
    end else if (capture_event) begin
      capture_value <= count; // R18
    end
  end

  // Comparator sampled on the count clock so a gate edge lands cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_clock <= 1'b0;
      synced_comparator_two_output <= 1'b0;
    end else begin
      count_clock <= raw_tick; // R22
      if (!gate_ctrl.comparator_sync_enable || raw_tick) begin
        synced_comparator_two_output <= comp_sync.level; // R22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_out <= 1'b0;
      osc_pin_a_oe <= 1'b0;
      osc_pin_b_oe <= 1'b0;
      overflow_irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      crystal_osc_out <= control.crystal_osc_enable &&
                         !xtal_sync.level; // R06
      osc_pin_a_oe <= !control.crystal_osc_enable && !osc_dir[0]; // R07
      osc_pin_b_oe <= !control.crystal_osc_enable && !osc_dir[1]; // R07
      overflow_irq <= overflow_flag && irq_en.overflow_irq_enable &&
                      irq_en.peripheral_irq_enable &&
                      irq_en.global_irq_enable; // R16 R17
      wake <= sleep && overflow_flag && control.timer_on &&
              irq_en.overflow_irq_enable &&
              irq_en.peripheral_irq_enable; // R17
    end
  end

  assign time_base = count; // R18

endmodule : gated_timer

// ==== core/pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output sync_out_t sync
);

  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

  always_comb begin
    sync.level = level;
    sync.rise = (s2 == s3) && s3 && !level;
    sync.fall = (s2 == s3) && !s3 && level;
  end

endmodule : pin_sync

// ==== core/prescaler.sv ====
`timescale 1ns/1ns
`include "timer_consts.svh"
module prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  output logic pulse
);

  logic [2:0] count;
  logic [2:0] last;

  always_comb begin
    unique case (prescale_select)
      `PRESCALE_DIV1: last = 3'h0; // R23
      `PRESCALE_DIV2: last = 3'h1; // R23
      `PRESCALE_DIV4: last = 3'h3; // R23
      `PRESCALE_DIV8: last = 3'h7; // R23
    endcase
  end

  assign pulse = tick && !clear && (count >= last); // R05

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 3'h0;
    end else if (clear) begin
      count <= 3'h0; // R05
    end else if (tick) begin
      count <= (count >= last) ? 3'h0 : count + 3'h1;
    end
  end

endmodule : prescaler

// ==== core/timer_consts.svh ====
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define OFS_CONTROL 12'h000
`define OFS_COUNT_LOW 12'h004
`define OFS_COUNT_HIGH 12'h008
`define OFS_GATE_CTRL 12'h00C
`define OFS_FLAGS 12'h010
`define OFS_IRQ_ENABLE 12'h014
`define OFS_OSC_PORT 12'h018

`define CONTROL_RESET 8'h00
`define GATE_CTRL_RESET 2'h0
`define IRQ_ENABLE_RESET 3'h0
`define OSC_DIR_RESET 2'h3
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF

`define INSTR_DIV_LAST 2'h3
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV2 2'h1
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV8 2'h3

`endif

// ==== core/timer_pkg.sv ====
package timer_pkg;

  typedef struct packed {
    logic gate_invert;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_disable;
    logic clock_source_select;
    logic timer_on;
  } control_t;

  typedef struct packed {
    logic gate_source_select;
    logic comparator_sync_enable;
  } gate_ctrl_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic overflow_irq_enable;
  } irq_enable_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } sync_out_t;

endpackage : timer_pkg

// ==== sim/pulse_source.sv ====
`timescale 1ns/1ns
// Pin idles low between bursts; each pulse is low then high
module pulse_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [3:0] pulses,
  input wire logic [3:0] half,
  output logic ext_clk,
  output logic busy
);
  logic [4:0] cnt;
  logic [3:0] left;
  assign busy = left != 4'h0;
  assign ext_clk = busy && cnt >= {1'b0, half};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 5'h00;
      left <= 4'h0;
    end else if (start && !busy) begin
      cnt <= 5'h00;
      left <= pulses;
    end else if (busy) begin
      if (cnt == {half, 1'b0} - 5'h01) begin
        cnt <= 5'h00;
        left <= left - 4'h1;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule : pulse_source

// ==== sim/test_gated_timer.sv ====
`timescale 1ns/1ns
`include "timer_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_gated_timer
  import timer_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0000000B;
  logic pready, pslverr, ext, busy, start = 0, gate_pin = 0, cmp = 0;
  logic sleep = 0, cap = 0, trig = 0, trig_acc = 0, oe_a, oe_b, irq, wake;
  logic xo, sco;
  logic [32:0] exp_rd;
  logic [15:0] time_base, capture_value, t;
  logic [3:0] np = 4'h4, half = 4'h3;
  logic [32:0] expq[$];
  int n_fail = 0, tests_run = 0, n, i;
  control_t ctl;
  always #5 pclk = ~pclk;
  pulse_source src (.pclk, .presetn, .start, .pulses(np), .half,
    .ext_clk(ext), .busy);
  gated_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_count_input(ext),
    .crystal_osc_in(ext), .crystal_osc_out(xo), .gate_pin,
    .comparator_two_output(cmp), .sleep, .capture_event(cap),
    .special_event_trigger(trig), .time_base, .capture_value,
    .count_clock(), .synced_comparator_two_output(sco), .osc_pin_a_oe(oe_a),
    .osc_pin_b_oe(oe_b), .overflow_irq(irq), .wake);
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      exp_rd = expq.pop_front();
      `CHK({pslverr, prdata}, exp_rd)
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge pclk);
    if (!w) expq.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    trig <= trig_acc;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    if (!pready) begin
      n_fail++;
      tally_and_finish();
    end
    psel <= 0;
    penable <= 0;
    trig <= 0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    bus(0, a, 32'h0, e);
  endtask : rd
  task automatic setctl();
    wr(`OFS_CONTROL, {24'h000000, ctl});
  endtask : setctl
  // Waits a fixed tail so the synchroniser has landed the last edge
  task automatic burst();
    int k;
    start <= 1;
    @(posedge pclk);
    start <= 0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy && k < 300);
    if (busy) begin
      n_fail++;
      tally_and_finish();
    end
    cyc(8);
  endtask : burst
  task automatic gap(output int c);
    int k;
    k = 0;
    t = time_base;
    while (time_base === t && k < 100) begin
      @(posedge pclk);
      k++;
    end
    t = time_base;
    c = 0;
    while (time_base === t && c < 100) begin
      @(posedge pclk);
      c++;
    end
    if (k == 100 || c == 100) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : gap
  initial begin
    ctl = '0;
    cyc(20);
    presetn <= 1;
    wr(12'h01C, 32'h0000_00FF);
    rd(`OFS_CONTROL, 33'h0);
    rd(12'h01C, {1'b1, 32'h0});
    repeat (3) begin
      r = rnd();
      wr(`OFS_COUNT_LOW, r);
      wr(`OFS_COUNT_HIGH, r >> 8);
      rd(`OFS_COUNT_LOW, {25'h0, r[7:0]});
      rd(`OFS_COUNT_HIGH, {25'h0, r[15:8]});
    end
    ctl.timer_on = 1;
    for (i = 0; i < 4; i++) begin
      ctl.prescale_select = i[1:0];
      setctl();
      gap(n);
      `CHK(n, 32'h4 << i)
    end
    sleep <= 1;
    cyc(2);
    t = time_base;
    cyc(70);
    `CHK(time_base, t)
    sleep <= 0;
    ctl = '0;
    ctl.clock_source_select = 1;
    setctl();
    wr(`OFS_COUNT_LOW, 32'h0);
    wr(`OFS_COUNT_HIGH, 32'h0);
    ctl.timer_on = 1;
    setctl();
    burst();
    rd(`OFS_COUNT_LOW, 33'h3);
    ctl.gate_enable = 1;
    gate_pin <= 1;
    setctl();
    burst();
    rd(`OFS_COUNT_LOW, 33'h3);
    ctl.gate_invert = 1;
    setctl();
    burst();
    rd(`OFS_COUNT_LOW, 33'h7);
    half <= 4'h6;
    wr(`OFS_GATE_CTRL, 32'h2);
    burst();
    rd(`OFS_COUNT_LOW, 33'h7);
    cmp <= 1;
    burst();
    rd(`OFS_COUNT_LOW, 33'hB);
    `CHK(sco, 1'b1)
    cap <= 1;
    @(posedge pclk);
    cap <= 0;
    cyc(2);
    `CHK(capture_value, 16'h000B)
    ctl.sync_disable = 1;
    setctl();
    wr(`OFS_GATE_CTRL, 32'h3);
    sleep <= 1;
    burst();
    sleep <= 0;
    rd(`OFS_COUNT_LOW, 33'hF);
    ctl = '0;
    setctl();
    @(posedge pclk);
    trig <= 1;
    @(posedge pclk);
    trig <= 0;
    rd(`OFS_COUNT_LOW, 33'h0);
    rd(`OFS_FLAGS, 33'h0);
    trig_acc = 1;
    wr(`OFS_COUNT_LOW, 32'h5A);
    trig_acc = 0;
    rd(`OFS_COUNT_LOW, 33'h5A);
    wr(`OFS_COUNT_HIGH, 32'hFF);
    wr(`OFS_COUNT_LOW, 32'hFF);
    ctl.timer_on = 1;
    setctl();
    cyc(12);
    sleep <= 1;
    rd(`OFS_FLAGS, 33'h1);
    for (i = 0; i < 8; i++) begin
      wr(`OFS_IRQ_ENABLE, i);
      cyc(2);
      `CHK(irq, i == 7)
      `CHK(wake, i[1:0] == 2'h3)
    end
    sleep <= 0;
    wr(`OFS_FLAGS, 32'h0);
    rd(`OFS_FLAGS, 33'h0);
    ctl = '0;
    setctl();
    wr(`OFS_OSC_PORT, 32'h0);
    cyc(2);
    `CHK({oe_a, oe_b}, 2'h3)
    `CHK(xo, 1'b0)
    ctl.crystal_osc_enable = 1;
    setctl();
    cyc(2);
    `CHK({oe_a, oe_b}, 2'h0)
    `CHK(xo, 1'b1)
    rd(`OFS_OSC_PORT, 33'h3);
    cyc(2);
    tally_and_finish();
  end
endmodule : test_gated_timer

// ==== sim/timer_chk.sv ====
`timescale 1ns/1ns
`include "timer_consts.svh"
module timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic capture_event,
  input wire logic special_event_trigger,
  input wire logic [15:0] time_base,
  input wire logic [15:0] capture_value,
  input wire logic count_clock,
  input wire logic wake
);
  logic acc;
  logic wr_cnt;
  assign acc = psel && penable && pwrite;
  assign wr_cnt = acc && (paddr == `OFS_COUNT_LOW ||
    paddr == `OFS_COUNT_HIGH);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_low;
    acc && paddr == `OFS_COUNT_LOW;
  endsequence
  sequence s_wr_high;
    acc && paddr == `OFS_COUNT_HIGH;
  endsequence
  property p_ready;
    s_setup |=> pready;
  endproperty
  property p_idle;
    !psel |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  property p_wr_low;
    s_wr_low |=> time_base[7:0] == $past(pwdata[7:0]);
  endproperty
  property p_wr_high;
    s_wr_high |=> time_base[15:8] == $past(pwdata[7:0]);
  endproperty
  // Steps other than write or clear are a single increment
  property p_step;
    $changed(time_base) && !$past(wr_cnt) && !$past(special_event_trigger)
      |-> time_base == $past(time_base) + 16'h0001;
  endproperty
  property p_clear;
    special_event_trigger && !wr_cnt |=> time_base == 16'h0000;
  endproperty
  property p_capture;
    capture_event |=> capture_value == $past(time_base);
  endproperty
  property p_tick;
    count_clock |=> !count_clock;
  endproperty
  property p_wake;
    wake |-> $past(sleep);
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  a_idle: assert property (p_idle)
    else $error("ready without setup");
  a_err: assert property (p_err)
    else $error("error response malformed");
  a_wr_low: assert property (p_wr_low)
    else $error("low byte write lost");
  a_wr_high: assert property (p_wr_high)
    else $error("high byte write lost");
  a_step: assert property (p_step)
    else $error("count jumped");
  a_clear: assert property (p_clear)
    else $error("trigger did not clear");
  a_capture: assert property (p_capture)
    else $error("capture value wrong");
  a_tick: assert property (p_tick)
    else $error("count clock too long");
  a_wake: assert property (p_wake)
    else $error("wake while awake");
endmodule : timer_chk

bind gated_timer timer_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep,
  .capture_event, .special_event_trigger, .time_base, .capture_value,
  .count_clock, .wake);
